// file: dv/epf_chk.sv
// pin assertions for the external program fetch strobe block
// assumes external_access_n is held steady around the fetches it judges
`timescale 1ns/1ns
module epf_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // core side
  input wire logic [15:0] pc,
  input wire logic xdata_busy,
  input wire logic xdata_done,
  // pins
  input wire logic external_access_n,
  input wire logic program_fetch_strobe_n,
  input wire logic address_latch,
  input wire logic data_read_n,
  input wire logic data_write_n,
  input wire logic p0_oe_n,
  input wire logic [7:0] p2_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_lat_one;
    address_latch |=> !address_latch;
  endproperty
  a_lat_one: assert property (p_lat_one) else $error("latch pulse too long");
  property p_str_two;
    $fell(program_fetch_strobe_n) |=> !program_fetch_strobe_n ##1 program_fetch_strobe_n;
  endproperty
  a_str_two: assert property (p_str_two) else $error("fetch strobe length");
  property p_lat_first;
    $fell(program_fetch_strobe_n) |-> $past(address_latch);
  endproperty
  a_lat_first: assert property (p_lat_first) else $error("strobe without latch");
  property p_p0_addr;
    address_latch |-> !p0_oe_n;
  endproperty
  a_p0_addr: assert property (p_p0_addr) else $error("port 0 idle at latch");
  property p_p2_hold;
    !program_fetch_strobe_n |-> $stable(p2_out);
  endproperty
  a_p2_hold: assert property (p_p2_hold) else $error("port 2 moved in strobe");
  // pc must also be steady, since a slot started under an old pc is legal
  property p_int_quiet;
    $fell(program_fetch_strobe_n) && external_access_n && $past(external_access_n, 5)
      && $past(pc, 3) == pc |-> pc > 16'h7fff;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("strobe on internal fetch");
  property p_rd_len;
    $fell(data_read_n) |-> $past(address_latch) ##0 !data_read_n [*4] ##1 data_read_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read cycle shape");
  property p_rd_excl;
    !data_read_n |-> program_fetch_strobe_n && !address_latch;
  endproperty
  a_rd_excl: assert property (p_rd_excl) else $error("pulse during read");
  property p_wr_data;
    !data_write_n |-> !p0_oe_n;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data missing");
  property p_period;
    address_latch && !external_access_n && !$past(external_access_n, 3) ##3 !xdata_busy
      |-> address_latch;
  endproperty
  a_period: assert property (p_period) else $error("latch rate broken");
  property p_done;
    $rose(xdata_busy) |-> xdata_busy [*8] ##[3:5] xdata_done;
  endproperty
  a_done: assert property (p_done) else $error("transfer length");
  c_fetch: cover property ($fell(program_fetch_strobe_n));
  c_read: cover property ($fell(data_read_n));
  c_write: cover property ($fell(data_write_n));
  c_done: cover property (xdata_done);
endmodule

// file: dv/epf_fetch_strobes_tb.sv
// bench for the external program fetch strobe block
// assumes one core_clk cycle per oscillator period
`timescale 1ns/1ns
module epf_fetch_strobes_tb;
  import epf_pkg::*;
  logic core_clk = 0, rstn = 0, hsel = 1, hwrite = 0, xdata_start = 0;
  logic xdata_write = 0, xdata_use_dptr = 0, external_access_n = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] pc = 0, fetch_addr, data_addr;
  logic [7:0] xdata_addr_low = 0, data_pointer_high = 0, xdata_wdata = 0, p2_latch = 0;
  logic [7:0] p0_out, p2_out, bus_q;
  logic hreadyout, hresp, xdata_busy, xdata_done, program_fetch_strobe_n;
  logic address_latch, data_read_n, data_write_n, p0_oe_n, p2_oe_n, lat_d, str_d;
  int num_errors = 0, compares = 0, cyc = 0, lat_n, str_n, rd_n, wr_n, dn_n;
  epf_fetch_strobes i_dut (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pc, .xdata_start,
    .xdata_write, .xdata_use_dptr, .xdata_addr_low, .data_pointer_high, .xdata_wdata,
    .p2_latch, .xdata_busy, .xdata_done, .external_access_n, .program_fetch_strobe_n,
    .address_latch, .data_read_n, .data_write_n, .p0_out, .p0_oe_n, .p2_out, .p2_oe_n);
  epf_mem_model i_mem (.core_clk, .address_latch, .program_fetch_strobe_n, .data_read_n,
    .data_write_n, .p0_out, .p2_out, .fetch_addr, .data_addr, .bus_q);
  initial forever #50 core_clk = ~core_clk;
  // counted mid-cycle so tasks may clear the counts at the rising edge
  always @(negedge core_clk) begin
    lat_n += int'(address_latch && !lat_d);
    str_n += int'(!program_fetch_strobe_n && str_d);
    rd_n += int'(!data_read_n);
    wr_n += int'(!data_write_n);
    dn_n += int'(xdata_done);
    lat_d = address_latch;
    str_d = program_fetch_strobe_n;
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic win(input int n);
    lat_n = 0;
    str_n = 0;
    rd_n = 0;
    wr_n = 0;
    dn_n = 0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    bus(0, SYSCTL_ADDR, 0, q);
    chk("control reset", q, 32'h20);
    chk("okay response", hresp, 0);
    bus(1, SYSCTL_ADDR, 32'hff, q);
    bus(0, SYSCTL_ADDR, 0, q);
    chk("control mask", q, 32'h30);
    bus(1, 32'h0, 32'hff, q);
    bus(0, 32'h0, 0, q);
    chk("unmapped", q, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_fetch(input logic ea, input logic [15:0] a, input int el, es);
    external_access_n <= ea;
    pc <= a;
    repeat (6) @(posedge core_clk);
    win(12);
    chk("latch pulses", lat_n, el);
    chk("fetch strobes", str_n, es);
    chk("port 2 driven", p2_oe_n, 0);
    if (es > 0)
      chk("fetch address", fetch_addr, a);
  endtask
  task automatic t_fetch_all();
    logic [31:0] q;
    t_fetch(0, 16'h12a5, 4, 4);
    t_fetch(1, 16'h0100, 4, 0);
    bus(0, STATUS_ADDR, 0, q);
    chk("status internal", q & 32'hffffff1f, 32'h08);
    t_fetch(1, 16'h7fff, 4, 0);
    t_fetch(1, 16'h8000, 4, 4);
    bus(1, SYSCTL_ADDR, 0, q);
    t_fetch(1, 16'h1fff, 0, 0);
    t_fetch(1, 16'h2000, 4, 0);
    t_fetch(0, 16'h1000, 4, 4);
    bus(1, SYSCTL_ADDR, 32'h20, q);
    $display("test fetch done");
  endtask
  task automatic t_xfer(input logic wr, dp);
    xdata_write <= wr;
    xdata_use_dptr <= dp;
    xdata_addr_low <= 8'h5a;
    data_pointer_high <= 8'hc3;
    p2_latch <= 8'h3c;
    xdata_wdata <= 8'h96;
    xdata_start <= 1'b1;
    win(0);
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      if (xdata_busy === 1'b1)
        xdata_start <= 1'b0;
    end
    chk("latch pulses", lat_n, 7);
    chk("fetch strobes", str_n, 5);
    chk("read cycles", rd_n, wr ? 0 : 4);
    chk("write cycles", wr_n, wr ? 4 : 0);
    chk("done pulses", dn_n, 1);
    chk("data address", data_addr, {dp ? 8'hc3 : 8'h3c, 8'h5a});
    $display("test transfer done");
  endtask
  task automatic t_reset();
    logic [31:0] q;
    bus(1, SYSCTL_ADDR, 0, q);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    bus(0, SYSCTL_ADDR, 0, q);
    chk("control after reset", q, 32'h20);
    t_fetch(1, 16'h0100, 4, 0);
    $display("test reset done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_fetch_all();
    for (int k = 0; k < 4; k++)
      t_xfer(k[0], k[1]);
    t_reset();
    tally_and_finish();
  end
endmodule
bind epf_fetch_strobes epf_chk i_chk (.core_clk(core_clk), .rstn(rstn), .pc(pc),
  .xdata_busy(xdata_busy), .xdata_done(xdata_done), .external_access_n(external_access_n),
  .program_fetch_strobe_n(program_fetch_strobe_n), .address_latch(address_latch),
  .data_read_n(data_read_n), .data_write_n(data_write_n), .p0_oe_n(p0_oe_n),
  .p2_out(p2_out));

// file: dv/epf_mem_model.sv
// outside address latch and shared code/data memory
// assumes it samples the pins on core_clk, one oscillator period a cycle
`timescale 1ns/1ns
module epf_mem_model (
  // clock
  input wire logic core_clk,
  // device pins
  input wire logic address_latch,
  input wire logic program_fetch_strobe_n,
  input wire logic data_read_n,
  input wire logic data_write_n,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p2_out,
  // what the memory saw
  output logic [15:0] fetch_addr,
  output logic [15:0] data_addr,
  output logic [7:0] bus_q
);
  logic [7:0] lat_q = 8'h00;
  logic rd_any_n;
  assign rd_any_n = program_fetch_strobe_n & data_read_n;
  // answers within the cycle, fast enough for the short fetch cycle
  assign bus_q = rd_any_n ? ~p0_out : lat_q ^ p2_out;
  // the last edge with the pulse high equals a capture on its fall
  always @(posedge core_clk) begin
    if (address_latch)
      lat_q <= p0_out;
    if (!program_fetch_strobe_n)
      fetch_addr <= {p2_out, lat_q};
    if (!data_read_n || !data_write_n)
      data_addr <= {p2_out, lat_q};
  end
endmodule

// file: hw/epf_fetch_strobes.sv
// external program fetch strobes, address latch pulse and port 0/2 address drive
// assumes the core holds pc steady through each fetch slot and keeps
// the transfer request fields stable until xdata_done
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module epf_fetch_strobes (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // ahb-lite register port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core side
  input wire logic [15:0] pc,
  input wire logic xdata_start,
  input wire logic xdata_write,
  input wire logic xdata_use_dptr,
  input wire logic [7:0] xdata_addr_low,
  input wire logic [7:0] data_pointer_high,
  input wire logic [7:0] xdata_wdata,
  input wire logic [7:0] p2_latch,
  output logic xdata_busy,
  output logic xdata_done,
  // pins
  input wire logic external_access_n,
  output logic program_fetch_strobe_n,
  output logic address_latch,
  output logic data_read_n,
  output logic data_write_n,
  output logic [7:0] p0_out,
  output logic p0_oe_n,
  output logic [7:0] p2_out,
  output logic p2_oe_n
);
  import epf_pkg::*;

  // ---------------------------------------------------------------
  // pin synchroniser and machine cycle phase
  // ---------------------------------------------------------------
  logic ea_n_s;
  logic [2:0] ph;
  logic ph_wrap;

  epf_sync2 #(.RST_VAL(1'b1)) u_ea_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .d(external_access_n),
    .q(ea_n_s)
  );

  // six periods per machine cycle, two three-period fetch slots
  epf_phase_ctr #(.W(3), .LAST(PH_LAST)) u_phase (
    .core_clk(core_clk),
    .rstn(rstn),
    .phase(ph),
    .wrap(ph_wrap)
  );

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  logic [7:0] sysctl_r;
  logic [7:0] sysctl_nxt;
  logic wpend_r;
  logic wpend_nxt;
  logic [31:0] waddr_r;
  logic [31:0] waddr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic [7:0] status_val;
  logic [7:0] sysctl_view;
  logic addr_phase;

  assign addr_phase = hsel && htrans[1] && hready;

  always_comb begin
    sysctl_nxt = sysctl_r;
    wpend_nxt = 1'b0;
    waddr_nxt = waddr_r;
    hrdata_nxt = hrdata_r;
    sysctl_view = sysctl_r;
    // only the enable and the neighbouring bit are writable, the rest read zero
    if (wpend_r && waddr_r == SYSCTL_ADDR) begin
      sysctl_nxt = hwdata[7:0] & SYSCTL_WMASK;
      sysctl_view = sysctl_nxt;
    end
    if (addr_phase) begin
      wpend_nxt = hwrite;
      waddr_nxt = haddr;
      if (!hwrite) begin
        // a read right behind a write sees the freshly written value
        case (haddr)
          SYSCTL_ADDR: hrdata_nxt = {24'h0, sysctl_view};
          STATUS_ADDR: hrdata_nxt = {24'h0, status_val};
          default: hrdata_nxt = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sysctl_r <= SYSCTL_RST;
      wpend_r <= 1'b0;
      waddr_r <= 32'h0;
      hrdata_r <= 32'h0;
    end else begin
      sysctl_r <= sysctl_nxt;
      wpend_r <= wpend_nxt;
      waddr_r <= waddr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // ---------------------------------------------------------------
  // fetch decisions
  // ---------------------------------------------------------------
  logic ext_code;
  logic ale_code_en;

  assign ext_code = !ea_n_s || (pc > INT_CODE_TOP);
  // external_access_n low overrides the enable bit
  assign ale_code_en = !ea_n_s || sysctl_r[LATCH_PULSE_ENABLE_BIT] || (pc > ALE_QUIET_TOP);

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  epf_state_type st_r;
  epf_state_type st_nxt;
  logic xwr_r;
  logic xwr_nxt;
  logic [7:0] xlo_r;
  logic [7:0] xlo_nxt;
  logic [7:0] xhi_r;
  logic [7:0] xhi_nxt;
  logic [7:0] xwd_r;
  logic [7:0] xwd_nxt;
  logic done_r;
  logic done_nxt;
  logic busy_r;
  logic busy_nxt;

  always_comb begin
    st_nxt = st_r;
    xwr_nxt = xwr_r;
    xlo_nxt = xlo_r;
    xhi_nxt = xhi_r;
    xwd_nxt = xwd_r;
    done_nxt = 1'b0;
    if (ph_wrap) begin
      case (st_r)
        EPF_ST_RUN: begin
          if (xdata_start) begin
            st_nxt = EPF_ST_XD1;
            xwr_nxt = xdata_write;
            xlo_nxt = xdata_addr_low;
            // pointer transfers use the pointer high byte, register-indirect the latch
            xhi_nxt = xdata_use_dptr ? data_pointer_high : p2_latch;
            xwd_nxt = xdata_wdata;
          end
        end
        EPF_ST_XD1: st_nxt = EPF_ST_XD2;
        EPF_ST_XD2: begin
          st_nxt = EPF_ST_RUN;
          done_nxt = 1'b1;
        end
        default: st_nxt = EPF_ST_RUN;
      endcase
    end
    busy_nxt = (st_nxt != EPF_ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r <= EPF_ST_RUN;
      xwr_r <= 1'b0;
      xlo_r <= 8'h0;
      xhi_r <= 8'h0;
      xwd_r <= 8'h0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      xwr_r <= xwr_nxt;
      xlo_r <= xlo_nxt;
      xhi_r <= xhi_nxt;
      xwd_r <= xwd_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign xdata_busy = busy_r;
  assign xdata_done = done_r;

  // ---------------------------------------------------------------
  // pin sequencing: each pin register takes what the current phase asks
  // ---------------------------------------------------------------
  logic slot_start;
  logic data_slot;
  logic xstrobe;
  logic ale_nxt;
  logic program_fetch_strobe_n_n_nxt;
  logic rd_n_nxt;
  logic wr_n_nxt;
  logic [7:0] p0_nxt;
  logic p0_oe_n_nxt;
  logic [7:0] p2_nxt;
  logic ale_r;
  logic program_fetch_strobe_n_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic [7:0] p0_r;
  logic p0_oe_n_r;
  logic [7:0] p2_r;
  logic fetch_ext_r;
  logic fetch_ext_nxt;

  assign slot_start = (ph == 3'h0) || (ph == PH_SLOT_B);
  // second slot of the first transfer cycle carries the data address
  assign data_slot = (st_r == EPF_ST_XD1) && (ph >= PH_SLOT_B);
  // strobe runs from phase 4 of the first cycle to phase 1 of the second
  assign xstrobe = ((st_r == EPF_ST_XD1) && (ph >= PH_XSTROBE_ON)) ||
                   ((st_r == EPF_ST_XD2) && (ph < PH_XSTROBE_OFF));

  always_comb begin
    ale_nxt = 1'b0;
    program_fetch_strobe_n_n_nxt = 1'b1;
    p0_nxt = 8'hff;
    p0_oe_n_nxt = 1'b1;
    p2_nxt = p2_r;
    fetch_ext_nxt = fetch_ext_r;
    if (slot_start) begin
      if (data_slot) begin
        // transfer address always gets its latch pulse
        ale_nxt = 1'b1;
        p0_nxt = xlo_r;
        p0_oe_n_nxt = 1'b0;
        p2_nxt = xhi_r;
        fetch_ext_nxt = 1'b0;
      end else if (st_r == EPF_ST_XD2 && ph == 3'h0) begin
        // strobe still active: pulse is dropped and port 2 keeps the data address
        ale_nxt = 1'b0;
        fetch_ext_nxt = 1'b0;
        // write data must not drop out in the middle of the write strobe
        if (xwr_r) begin
          p0_nxt = xwd_r;
          p0_oe_n_nxt = 1'b0;
        end
      end else begin
        // pulses follow ale_code_en at each slot start, fetch or not
        ale_nxt = ale_code_en;
        p0_nxt = pc[7:0];
        p0_oe_n_nxt = 1'b0;
        // no fetch strobe in the second cycle of a transfer
        fetch_ext_nxt = ext_code && (st_r != EPF_ST_XD2);
        // port latch value is never touched, only the pin mux switches
        p2_nxt = ext_code ? pc[15:8] : p2_latch;
      end
    end else begin
      // latch pulse has ended, strobe follows for the two remaining periods
      program_fetch_strobe_n_n_nxt = !fetch_ext_r;
      if (xstrobe && xwr_r) begin
        p0_nxt = xwd_r;
        p0_oe_n_nxt = 1'b0;
      end
    end
    if (st_r == EPF_ST_XD2 && ph == PH_XSTROBE_OFF && xwr_r) begin
      // write data stays one period past the write strobe
      p0_nxt = xwd_r;
      p0_oe_n_nxt = 1'b0;
    end
    rd_n_nxt = !(xstrobe && !xwr_r);
    wr_n_nxt = !(xstrobe && xwr_r);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ale_r <= 1'b0;
      program_fetch_strobe_n_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      p0_r <= 8'hff;
      p0_oe_n_r <= 1'b1;
      p2_r <= 8'hff;
      fetch_ext_r <= 1'b0;
    end else begin
      ale_r <= ale_nxt;
      program_fetch_strobe_n_n_r <= program_fetch_strobe_n_n_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      p0_r <= p0_nxt;
      p0_oe_n_r <= p0_oe_n_nxt;
      p2_r <= p2_nxt;
      fetch_ext_r <= fetch_ext_nxt;
    end
  end

  assign address_latch = ale_r;
  assign program_fetch_strobe_n = program_fetch_strobe_n_n_r;
  assign data_read_n = rd_n_r;
  assign data_write_n = wr_n_r;
  assign p0_out = p0_r;
  assign p0_oe_n = p0_oe_n_r;
  assign p2_out = p2_r;
  // port 2 carries the address or the port latch value here, and it is driven at all times
  assign p2_oe_n = 1'b0;

  // ---------------------------------------------------------------
  // status view
  // ---------------------------------------------------------------
  assign status_val = {ph, 1'b0, ea_n_s, busy_r, fetch_ext_r, ext_code};

endmodule

// file: hw/epf_phase_ctr.sv
// oscillator period counter within one machine cycle
// assumes one count per core_clk edge
`timescale 1ns/1ns
module epf_phase_ctr #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] LAST = 3'h5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // phase and last-phase flag
  output logic [W-1:0] phase,
  output logic wrap
);
  logic [W-1:0] ph_r;
  logic [W-1:0] ph_nxt;

  always_comb begin
    ph_nxt = (ph_r == LAST) ? '0 : W'(ph_r + 1'b1);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ph_r <= '0;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  assign phase = ph_r;
  assign wrap = (ph_r == LAST);
endmodule

// file: hw/epf_pkg.sv
// constants, types and the register map of the external program fetch strobe block
// assumes one oscillator period per core_clk cycle and a 32-bit AHB-Lite register port
//
// Functional notes
// - fetch code externally while external_access_n low
// - fetch code externally when pc above 7fff
// - port 2 drives address, latch left untouched
// - port 2 carries pc, pointer or latch high
// - fetch strobe only for external code fetches
// - two fetch strobes per cycle, one per transfer (code: one in the first transfer cycle, none in the second)
// - external data read cycle spans six periods (data_read_n is low for four periods here)
// - program fetch cycle spans three periods
// - low address valid at latch pulse fall
// - two latch pulses per cycle when enabled, one fewer per transfer
// - no latch pulse while data strobes active
// - latch pulse steady rate without data accesses
// - latch enable off: pulses only data, pc>1fff
// - external_access_n low forces latch pulses on
// - latch pulses enabled after reset, write keeps
// - machine cycle is six oscillator periods

package epf_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned OSC_PERIOD_NS = 100;
  localparam int unsigned OSC_CLKS = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned MC_OSC = 6;
  localparam int unsigned FETCH_OSC = 3;
  localparam logic [2:0] PH_LAST = 3'(MC_OSC * OSC_CLKS - 1);
  localparam logic [2:0] PH_SLOT_B = 3'(FETCH_OSC * OSC_CLKS);
  localparam logic [2:0] PH_XSTROBE_ON = 3'h4;
  localparam logic [2:0] PH_XSTROBE_OFF = 3'h2;

  // ---------------------------------------------------------------
  // address limits
  // ---------------------------------------------------------------
  localparam logic [15:0] INT_CODE_TOP = 16'h7fff;
  localparam logic [15:0] ALE_QUIET_TOP = 16'h1fff;

  // ---------------------------------------------------------------
  // register map: printed offsets are word indices
  // ---------------------------------------------------------------
  localparam logic [7:0] SYSCTL_IDX = 8'hb1;
  localparam logic [7:0] STATUS_IDX = 8'hb2;
  localparam logic [31:0] SYSCTL_ADDR = {22'h0, SYSCTL_IDX, 2'h0};
  localparam logic [31:0] STATUS_ADDR = {22'h0, STATUS_IDX, 2'h0};
  localparam int unsigned LATCH_PULSE_ENABLE_BIT = 5;
  localparam logic [7:0] SYSCTL_RST = 8'h20;
  localparam logic [7:0] SYSCTL_WMASK = 8'h30;

  typedef enum logic [1:0] {EPF_ST_RUN, EPF_ST_XD1, EPF_ST_XD2} epf_state_type;

endpackage

// file: hw/epf_sync2.sv
// two flip-flop synchroniser for pin inputs
// assumes the pin is asynchronous to core_clk
`timescale 1ns/1ns
module epf_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pin and synchronised level
  input wire logic d,
  output logic q
);
  logic meta_r;
  logic q_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule
